// ==== src/srfb_top.sv ====
// Purpose: receive frame buffer with AHB-Lite register access
// Assumes: single clock, line receiver delivers bytes with end-of-frame marks
// Notes: reading the data register pops one byte while a complete frame is stored, else it returns zero
`timescale 1ns/1ns
module srfb_top import srfb_pkg::*; #(
  parameter int DEPTH = SRFB_DEPTH,
  parameter int MAXF = SRFB_MAXF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire srfb_byte_t rx_byte,
  input wire logic rx_break,
  output logic irq,
  output logic multidrop_en
);
  ////////////////////////////////////////////////////////////////////////
  srfb_cfg_t cfg_reg;
  logic run_reg;
  logic [SRFB_IRQ_W-1:0] stat_reg;
  logic [SRFB_IRQ_W-1:0] mask_reg;
  logic [7:0] mem [0:DEPTH-1];
  logic [DEPTH-1:0] last_mem;
  logic [SRFB_AW-1:0] wr_ptr_reg;
  logic [SRFB_AW-1:0] rd_ptr_reg;
  logic [SRFB_AW-1:0] fstart_reg;
  logic [SRFB_AW:0] count_reg;
  logic [SRFB_AW:0] pend_reg;
  logic [SRFB_AW:0] frames_reg; // whole-buffer mode may hold many short frames
  logic drop_reg;
  logic boot_reg;
  logic ph_reg;
  logic ph_wr_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] hrdata_reg;

  function automatic logic [SRFB_AW-1:0] ptr_inc(input logic [SRFB_AW-1:0] p);
    ptr_inc = (p == SRFB_AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus address phase and decoded events
  logic take;
  logic wr_cfg, wr_ctrl, wr_mask, rd_stat, rd_data;
  logic run_next, flush, pop, frame_start, overwrite, limit_hit, full, push;
  assign take = hsel && hready && (htrans == SRFB_HTRANS_NONSEQ);
  assign wr_cfg = ph_reg && ph_wr_reg && (ph_addr_reg == SRFB_CFG_OFS);
  assign wr_ctrl = ph_reg && ph_wr_reg && (ph_addr_reg == SRFB_CTRL_OFS);
  assign wr_mask = ph_reg && ph_wr_reg && (ph_addr_reg == SRFB_MASK_OFS);
  assign rd_stat = take && !hwrite && (haddr[7:0] == SRFB_IRQ_OFS);
  assign rd_data = take && !hwrite && (haddr[7:0] == SRFB_DATA_OFS);
  assign run_next = wr_ctrl ? hwdata[SRFB_CTRL_RUN_BIT] : run_reg;
  assign flush = (wr_ctrl && hwdata[SRFB_CTRL_FLUSH_BIT])
    || (cfg_reg.clr_start && ((!run_reg && run_next) || boot_reg));
  assign pop = rd_data && (frames_reg != '0) && (count_reg != pend_reg);
  assign limit_hit = (cfg_reg.limit != SRFB_LIM_WHOLE) && (frames_reg >= (SRFB_AW+1)'(cfg_reg.limit));
  assign full = (count_reg == (SRFB_AW+1)'(DEPTH));
  assign frame_start = rx_byte.valid && (pend_reg == '0);
  assign overwrite = !cfg_reg.prot && (cfg_reg.limit == 4'h1) && (frames_reg != '0);
  // protected full buffer drops whole frame
  assign push = rx_byte.valid && !flush && !drop_reg && !(frame_start && (limit_hit && !overwrite))
    && !(full && !(frame_start && overwrite));

  ////////////////////////////////////////////////////////////////////////
  // parameters with defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= SRFB_CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg.clr_start <= hwdata[SRFB_CFG_CLR_BIT];
      cfg_reg.prot <= hwdata[SRFB_CFG_PROT_BIT];
      cfg_reg.limit <= (hwdata[SRFB_CFG_LIM_LSB +: 4] > 4'(MAXF)) ? 4'(MAXF) : hwdata[SRFB_CFG_LIM_LSB +: 4];
      if (hwdata[SRFB_CFG_IDLE_LSB +: 2] != 2'b11) begin
        cfg_reg.idle <= srfb_idle_t'(hwdata[SRFB_CFG_IDLE_LSB +: 2]);
      end
      cfg_reg.md_req <= hwdata[SRFB_CFG_MD_BIT];
    end
  end

  // host run state and power-up marker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      run_reg <= run_next;
      boot_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multidrop_en <= 1'b0;
    end else begin
      multidrop_en <= 1'b0 & cfg_reg.md_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte store
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[(frame_start && overwrite) ? rd_ptr_reg : wr_ptr_reg] <= rx_byte.data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_mem <= '0;
    end else if (push) begin
      last_mem[(frame_start && overwrite) ? rd_ptr_reg : wr_ptr_reg] <= rx_byte.last;
    end
  end

  // pointers, occupancy and frame count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fstart_reg <= '0;
      count_reg <= '0;
      pend_reg <= '0;
      frames_reg <= '0;
      drop_reg <= 1'b0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fstart_reg <= '0;
      count_reg <= '0;
      pend_reg <= '0;
      frames_reg <= '0;
      drop_reg <= 1'b0;
    end else if (rx_byte.valid && frame_start && overwrite && !drop_reg) begin
      // restart store over the old frame
      wr_ptr_reg <= ptr_inc(rd_ptr_reg);
      fstart_reg <= rd_ptr_reg;
      count_reg <= (SRFB_AW+1)'(1);
      pend_reg <= rx_byte.last ? '0 : (SRFB_AW+1)'(1);
      frames_reg <= rx_byte.last ? frames_reg : '0;
    end else begin
      drop_reg <= rx_byte.valid ? (!push && !rx_byte.last) || (drop_reg && !rx_byte.last) : drop_reg;
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
        if (frame_start) begin
          fstart_reg <= wr_ptr_reg;
        end
      end else if (rx_byte.valid && pend_reg != '0) begin
        wr_ptr_reg <= fstart_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      // rollback also covers a pop in the same cycle
      if (!push && rx_byte.valid && pend_reg != '0) begin
        count_reg <= count_reg - pend_reg - (pop ? 1'b1 : 1'b0);
      end else if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (!push && pop) begin
        count_reg <= count_reg - 1'b1;
      end
      if (push) begin
        pend_reg <= rx_byte.last ? '0 : pend_reg + 1'b1;
      end else if (rx_byte.valid) begin
        pend_reg <= '0;
      end
      frames_reg <= frames_reg + ((push && rx_byte.last) ? 1'b1 : 1'b0)
        - ((pop && last_mem[rd_ptr_reg]) ? 1'b1 : 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events, cleared by reading; a new event wins over the clear
  logic [SRFB_IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[SRFB_IRQ_FRAME_BIT] = push && rx_byte.last;
    ev[SRFB_IRQ_OVF_BIT] = rx_byte.valid && !push && !flush && !drop_reg;
    // break only for A high idle
    ev[SRFB_IRQ_BREAK_BIT] = rx_break && (cfg_reg.idle == SRFB_IDLE_AHIGH);
  end

  logic [SRFB_IRQ_W-1:0] stat_next;
  logic [SRFB_IRQ_W-1:0] mask_next;
  // set wins over the read clear; irq follows next status and mask
  assign stat_next = (rd_stat ? '0 : stat_reg) | ev;
  assign mask_next = wr_mask ? hwdata[SRFB_IRQ_W-1:0] : mask_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq <= |(stat_next & mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus data phase: zero wait, read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= '0;
      hrdata_reg <= '0;
    end else begin
      ph_reg <= take;
      ph_wr_reg <= take && hwrite;
      ph_addr_reg <= haddr[7:0];
      if (take && !hwrite) begin
        case (haddr[7:0])
          SRFB_CFG_OFS: hrdata_reg <= 32'(cfg_reg.clr_start) << SRFB_CFG_CLR_BIT
            | 32'(cfg_reg.prot) << SRFB_CFG_PROT_BIT | 32'(cfg_reg.limit) << SRFB_CFG_LIM_LSB
            | 32'(cfg_reg.idle) << SRFB_CFG_IDLE_LSB | 32'(cfg_reg.md_req) << SRFB_CFG_MD_BIT;
          SRFB_CTRL_OFS: hrdata_reg <= 32'(run_reg) << SRFB_CTRL_RUN_BIT;
          SRFB_STAT_OFS: hrdata_reg <= 32'(frames_reg);
          SRFB_IRQ_OFS: hrdata_reg <= 32'(stat_reg);
          SRFB_MASK_OFS: hrdata_reg <= 32'(mask_reg);
          SRFB_DATA_OFS: hrdata_reg <= pop ? (32'(mem[rd_ptr_reg]) | 32'(1) << SRFB_DATA_VALID_BIT
            | 32'(last_mem[rd_ptr_reg]) << SRFB_DATA_LAST_BIT) : 32'h0000_0000;
          SRFB_LEVEL_OFS: hrdata_reg <= 32'(count_reg);
          default: hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// ==== src/srfb_pkg.sv ====
// Purpose: constants and types for the serial receive frame buffer
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes: byte-wide frames arrive on a simple strobe interface from the line receiver
package srfb_pkg;
  localparam int SRFB_DEPTH = 2000;
  localparam int SRFB_AW = 11;
  localparam int SRFB_MAXF = 10;
  localparam int SRFB_FCW = 4;
  // register byte offsets
  localparam logic [7:0] SRFB_CFG_OFS = 8'h00;
  localparam logic [7:0] SRFB_CTRL_OFS = 8'h04;
  localparam logic [7:0] SRFB_STAT_OFS = 8'h08;
  localparam logic [7:0] SRFB_IRQ_OFS = 8'h0C;
  localparam logic [7:0] SRFB_MASK_OFS = 8'h10;
  localparam logic [7:0] SRFB_DATA_OFS = 8'h14;
  localparam logic [7:0] SRFB_LEVEL_OFS = 8'h18;
  // config fields
  localparam int SRFB_CFG_CLR_BIT = 0;
  localparam int SRFB_CFG_PROT_BIT = 1;
  localparam int SRFB_CFG_LIM_LSB = 4;
  localparam int SRFB_CFG_IDLE_LSB = 8;
  localparam int SRFB_CFG_MD_BIT = 12;
  // control fields
  localparam int SRFB_CTRL_RUN_BIT = 0;
  localparam int SRFB_CTRL_FLUSH_BIT = 1;
  // interrupt status fields
  localparam int SRFB_IRQ_FRAME_BIT = 0;
  localparam int SRFB_IRQ_OVF_BIT = 1;
  localparam int SRFB_IRQ_BREAK_BIT = 2;
  localparam int SRFB_IRQ_W = 3;
  // data register fields
  localparam int SRFB_DATA_VALID_BIT = 8;
  localparam int SRFB_DATA_LAST_BIT = 9;
  localparam logic [1:0] SRFB_HTRANS_NONSEQ = 2'h2;
  localparam logic [3:0] SRFB_LIM_WHOLE = 4'h0;

  typedef enum logic [1:0] {
    SRFB_IDLE_NONE = 2'b00,
    SRFB_IDLE_AHIGH = 2'b01,
    SRFB_IDLE_ALOW = 2'b10
  } srfb_idle_t;

  typedef struct packed {
    logic md_req;
    srfb_idle_t idle;
    logic [3:0] limit;
    logic prot;
    logic clr_start;
  } srfb_cfg_t;

  localparam srfb_cfg_t SRFB_CFG_RST = '{md_req: 1'b0, idle: SRFB_IDLE_AHIGH,
    limit: SRFB_LIM_WHOLE, prot: 1'b1, clr_start: 1'b0};

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } srfb_byte_t;
endpackage

// ==== tb/srfb_sva.sv ====
// Purpose: bus and interrupt checks for the receive frame buffer
// Assumes: sees only the top module ports
// Notes: bound into every srfb_top
`timescale 1ns/1ns
module srfb_sva import srfb_pkg::*; #(parameter int DEPTH = SRFB_DEPTH, parameter int MAXF = SRFB_MAXF) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire srfb_byte_t rx_byte,
  input wire logic rx_break,
  input wire logic irq,
  input wire logic multidrop_en
);
  logic [3:0] hist_reg;
  logic rd_tk;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////
  // recent causes that may raise the interrupt
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) hist_reg <= 4'h0;
    else hist_reg <= {hist_reg[2:0], rx_byte.valid | rx_break | (hsel & hready & hwrite & htrans[1])};
  assign rd_tk = hsel & hready & !hwrite & (htrans == SRFB_HTRANS_NONSEQ);
  sequence s_rd(logic [7:0] a);
    rd_tk && haddr == {24'h0, a};
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_no_multidrop: assert property (!multidrop_en)
    else $error("multidrop enable high");
  chk_quiet_reset: assert property ($rose(hresetn) |-> !irq)
    else $error("interrupt high after reset");
  chk_irq_cause: assert property ($rose(irq) |-> hist_reg != 4'h0)
    else $error("interrupt rose without cause");
  chk_unmapped_zero: assert property (s_rd(8'h1C) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_data_word: assert property (s_rd(SRFB_DATA_OFS) |=> hrdata[31:10] == 22'h0 && (!hrdata[9] || hrdata[8]))
    else $error("data word malformed");
  chk_level_bound: assert property (s_rd(SRFB_LEVEL_OFS) |=> hrdata <= DEPTH)
    else $error("level above depth");
  chk_rdata_hold: assert property (!rd_tk |=> $stable(hrdata))
    else $error("read data moved without read");
endmodule
//////////////////////////////////////////////////////////////////////
bind srfb_top srfb_sva #(.DEPTH(DEPTH), .MAXF(MAXF)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_byte(rx_byte), .rx_break(rx_break), .irq(irq),
  .multidrop_en(multidrop_en));

// ==== tb/srfb_line_model.sv ====
// Purpose: remote line partner sending framed bytes
// Assumes: bytes already decoded by the line receiver
// Notes: data lines carry the inverted last value between frames
`timescale 1ns/1ns
module srfb_line_model import srfb_pkg::*; (
  input wire logic hclk,
  output srfb_byte_t rx_byte,
  output logic rx_break
);
  // quiet line at time zero
  initial begin
    rx_byte = '0;
    rx_break = 1'b0;
  end
  task automatic send(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      rx_byte <= '{valid: 1'b1, last: i == n - 1, data: base + 8'(i)};
    end
    @(posedge hclk);
    rx_byte <= '{valid: 1'b0, last: 1'b0, data: ~rx_byte.data};
  endtask
  task automatic brk();
    @(posedge hclk);
    rx_break <= 1'b1;
    @(posedge hclk);
    rx_break <= 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: register level tests of the receive frame buffer
// Assumes: line model drives the receive side
// Notes: every path ends in close_out
`timescale 1ns/1ns
module tb_top import srfb_pkg::*; ;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq, multidrop_en, rx_break;
  srfb_byte_t rx_byte;
  int mismatches = 0, checks_done = 0;
  // bus clock
  always #25 hclk = ~hclk;
  srfb_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_byte(rx_byte), .rx_break(rx_break), .irq(irq), .multidrop_en(multidrop_en));
  srfb_line_model line (.hclk(hclk), .rx_byte(rx_byte), .rx_break(rx_break));
  //////////////////////////////////////////////////////////////////////
  // one single bus transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= SRFB_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic expect_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    expect_eq(nm, e, rd);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (10000) @(posedge hclk);
    mismatches++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("cfg", SRFB_CFG_OFS, 32'h102);
    rdchk("unmapped", 8'h1C, 32'h0);
    xfer(1'b1, SRFB_MASK_OFS, 32'h7);
    line.send(3, 8'hA0);
    repeat (3) @(posedge hclk);
    expect_eq("irq", 32'h1, {31'h0, irq});
    rdchk("irq stat", SRFB_IRQ_OFS, 32'h1);
    expect_eq("irq clear", 32'h0, {31'h0, irq});
    rdchk("frames", SRFB_STAT_OFS, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rdchk("data", SRFB_DATA_OFS, (i < 3) ? {22'h0, i == 2, 1'b1, 8'hA0 + 8'(i)} : 32'h0);
    end
    xfer(1'b1, SRFB_MASK_OFS, 32'h0);
    line.send(1, 8'h55);
    repeat (3) @(posedge hclk);
    expect_eq("masked irq", 32'h0, {31'h0, irq});
    xfer(1'b1, SRFB_CTRL_OFS, 32'h2);
    xfer(1'b1, SRFB_CFG_OFS, 32'h122);
    for (int f = 0; f < 3; f++) line.send(2, 8'h30 + 8'(f * 2));
    rdchk("frames", SRFB_STAT_OFS, 32'h2);
    rdchk("irq stat", SRFB_IRQ_OFS, 32'h3);
    rdchk("data", SRFB_DATA_OFS, 32'h130);
    xfer(1'b1, SRFB_CTRL_OFS, 32'h2);
    xfer(1'b1, SRFB_CFG_OFS, 32'h110);
    line.send(2, 8'h10);
    line.send(2, 8'h20);
    rdchk("frames", SRFB_STAT_OFS, 32'h1);
    rdchk("data", SRFB_DATA_OFS, 32'h120);
    xfer(1'b1, SRFB_CFG_OFS, 32'h103);
    line.send(1, 8'h77);
    xfer(1'b1, SRFB_CTRL_OFS, 32'h1);
    rdchk("frames", SRFB_STAT_OFS, 32'h0);
    xfer(1'b0, SRFB_IRQ_OFS, 32'h0);
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, SRFB_CFG_OFS, 32'h2 | (32'(k) << 8));
      line.brk();
      repeat (3) @(posedge hclk);
      rdchk("break", SRFB_IRQ_OFS, (k == 1) ? 32'h4 : 32'h0);
    end
    xfer(1'b1, SRFB_CFG_OFS, 32'h3F2);
    rdchk("cfg clamp", SRFB_CFG_OFS, 32'h2A2);
    xfer(1'b1, SRFB_CFG_OFS, 32'h1102);
    expect_eq("multidrop", 32'h0, {31'h0, multidrop_en});
    xfer(1'b1, SRFB_CTRL_OFS, 32'h2);
    for (int f = 0; f < 20; f++) line.send(1, 8'(f));
    rdchk("many frames", SRFB_STAT_OFS, 32'h14);
    xfer(1'b1, SRFB_CTRL_OFS, 32'h2);
    for (int f = 0; f < 10; f++) line.send(200, 8'h00);
    line.send(5, 8'hEE);
    rdchk("level", SRFB_LEVEL_OFS, 32'(SRFB_DEPTH));
    rdchk("frames", SRFB_STAT_OFS, 32'hA);
    rdchk("irq stat", SRFB_IRQ_OFS, 32'h3);
    rdchk("kept data", SRFB_DATA_OFS, 32'h100);
    close_out();
  end
endmodule
